/* hw/rx_status.sv */
// Receive path status: lane map, CRC, truncation, parity, faults.
// Assumes all inputs come from logic on the receive clock and
// an Avalon-MM master for the register file.
//
// Summary of operation
// - Each PCS lane reports its physical lane
// - Lane index meaningful only while synced
// - Demux flag set while lane demultiplexed
// - Complemented CRC is poisoned, other mismatch bad
// - Bad CRC count reports plain bad frames
// - Poisoned count nonzero per poisoned frame
// - Event outputs pulse one cycle each
// - Truncation pulses when length passes limit
// - Internal fault on pattern, alignment, BER
// - Received fault after enough fault sequences
// - Lane parity error pulses on mismatch
`timescale 1ns/1ps
`default_nettype none
module rx_status import rx_stat_pkg::*; (
    input  wire logic                  I_MCLK,           // Receive clock
    input  wire logic                  I_RESET,          // Async reset
    input  wire logic [7:0]            I_AVM_ADDRESS,    // Byte address
    input  wire logic                  I_AVM_READ,       // Read request
    input  wire logic                  I_AVM_WRITE,      // Write request
    input  wire logic [31:0]           I_AVM_WRITEDATA,  // Write data
    input  wire logic [3:0]            I_AVM_BYTEENABLE, // Byte lanes
    input  wire phys_lane_t [NUM_LANES-1:0] I_PHYS_LANE, // Marker lock per lane
    input  wire logic                  I_DESKEW_DONE,    // Lanes aligned
    input  wire bip_chk_t [NUM_LANES-1:0] I_BIP_CHK,     // Parity checks
    input  wire fcs_seg_t [NUM_SEG-1:0] I_FCS_SEG,       // Frame ends
    input  wire logic                  I_RX_VALID,       // Data beat
    input  wire logic                  I_RX_SOP,         // Frame start
    input  wire logic                  I_RX_EOP,         // Frame end
    input  wire logic [BYTES_W-1:0]    I_RX_BYTES,       // Bytes in beat
    input  wire logic                  I_TX_TEST_PATTERN,// Pattern generation
    input  wire logic                  I_HI_BER,         // High error rate
    input  wire logic                  I_COL_VALID,      // Column strobe
    input  wire logic                  I_LF_SEQ,         // Fault sequence
    output logic [31:0]                O_AVM_READDATA,   // Read data
    output logic                       O_AVM_WAITREQUEST,// Bus stall
    output logic                       O_IRQ,            // Interrupt level
    output logic [NUM_LANES-1:0][LANE_W-1:0] O_RX_LANE_MAP_INDEX, // Lane map
    output logic [NUM_LANES-1:0]       O_RX_LANE_SYNC_FLAGS,   // Lane synced
    output logic [NUM_LANES-1:0]       O_RX_LANE_DEMUX_FLAGS,  // Lane demuxed
    output logic [CNT_W-1:0]           O_RX_BAD_CRC_COUNT,     // Bad CRC
    output logic [CNT_W-1:0]           O_RX_POISONED_CRC_COUNT,// Poisoned CRC
    output logic                       O_RX_TRUNCATED,         // Cut frame
    output logic                       O_RX_INTERNAL_LOCAL_FAULT, // Own fault
    output logic                       O_RX_RECEIVED_LOCAL_FAULT, // Far fault
    output logic [NUM_LANES-1:0]       O_RX_LANE_PARITY_ERROR  // Parity
);
    // All block state
    typedef struct packed {
        logic [NUM_LANES-1:0][LANE_W-1:0] map;  // Lane map
        logic [NUM_LANES-1:0] sync;             // Sync flags
        logic [NUM_LANES-1:0] demux;            // Demux flags
        logic [NUM_LANES-1:0] bip;              // Parity pulses
        logic [CNT_W-1:0]     bad;              // Bad count pulse
        logic [CNT_W-1:0]     stomp;            // Poisoned count pulse
        logic                 trunc;            // Truncation pulse
        logic                 cut;              // Current frame cut
        logic [15:0]          len;              // Bytes so far
        logic                 ilf;              // Internal fault
        logic                 rlf;              // Received fault
        logic [LEN_W-1:0]     limit;            // Length limit
        logic [EV_W-1:0]      ist;              // Event status
        logic [EV_W-1:0]      imsk;             // Event mask
        logic                 irq;              // Interrupt
        logic                 waitreq;          // Bus stall
        logic [31:0]          rdata;            // Read data
    } top_reg_t;

    top_reg_t q;                                // Current state
    top_reg_t d;                                // Next state

    logic [CNT_W-1:0] bad_cnt;                  // Classifier bad count
    logic [CNT_W-1:0] stomp_cnt;                // Classifier poisoned count
    logic             rlf_lvl;                  // Fault detector level
    logic [NUM_SEG-1:0] seg_valid;              // Segment ends
    logic [NUM_SEG-1:0][31:0] seg_rx;           // Segment received CRC
    logic [NUM_SEG-1:0][31:0] seg_calc;         // Segment computed CRC

    // Byte enables widened to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction

    // Merge written bytes into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        return (old & ~be_mask(be)) | (wd & be_mask(be));
    endfunction

    // Split frame ends for the classifier
    always_comb begin
        for (int s = 0; s < NUM_SEG; s++) begin
            seg_valid[s] = I_FCS_SEG[s].valid;
            seg_rx[s]    = I_FCS_SEG[s].rx;
            seg_calc[s]  = I_FCS_SEG[s].calc;
        end
    end

    // CRC classification
    rx_fcs_classify u_fcs (
        .i_seg_valid (seg_valid),
        .i_seg_rx    (seg_rx),
        .i_seg_calc  (seg_calc),
        .o_bad_cnt   (bad_cnt),
        .o_stomp_cnt (stomp_cnt)
    );

    // Received local fault detector
    rx_lf_monitor #(
        .TRIP   (LF_TRIP),
        .WINDOW (LF_WINDOW)
    ) u_lf (
        .i_clk       (I_MCLK),
        .i_reset     (I_RESET),
        .i_col_valid (I_COL_VALID),
        .i_lf_seq    (I_LF_SEQ),
        .o_fault     (rlf_lvl)
    );

    // Next state of everything
    always_comb begin
        logic [16:0]     len_sum;
        logic            cut_base;
        logic [EV_W-1:0] ev;
        logic [31:0]     wr_lim;
        logic            wr_acc;
        logic            rd_acc;
        len_sum  = '0;
        cut_base = 1'b0;
        ev       = '0;
        wr_lim   = '0;
        rd_acc   = 1'b0;
        wr_acc   = 1'b0;
        d        = q;

        // Lane map from physical lane markers
        for (int p = 0; p < NUM_LANES; p++) begin
            d.map[p]  = '0;
            d.sync[p] = 1'b0;
            for (int l = 0; l < NUM_LANES; l++) begin
                if (I_PHYS_LANE[l].lock && I_PHYS_LANE[l].id == 5'(p)) begin
                    d.map[p]  = 5'(l);
                    d.sync[p] = 1'b1;
                end
            end
            // Demuxed once synced and aligned
            d.demux[p] = d.sync[p] & I_DESKEW_DONE;
        end

        // Parity mismatch pulses, one bit per lane
        for (int p = 0; p < NUM_LANES; p++) begin
            d.bip[p] = I_BIP_CHK[p].valid &&
                       (I_BIP_CHK[p].rx != I_BIP_CHK[p].calc);
        end

        // CRC counts stand one cycle
        d.bad   = bad_cnt;
        d.stomp = stomp_cnt;

        // Length tracking and truncation
        d.trunc = 1'b0;
        if (I_RX_VALID) begin
            cut_base = I_RX_SOP ? 1'b0 : q.cut;
            len_sum  = (I_RX_SOP ? 17'h00000 : {1'b0, q.len}) +
                       {9'h000, I_RX_BYTES};
            // Pulse once when the limit is passed
            if (!cut_base && len_sum > {2'b00, q.limit}) begin
                d.trunc = 1'b1;
                cut_base = 1'b1;
            end
            d.len = len_sum[16] ? 16'hFFFF : len_sum[15:0];
            d.cut = cut_base;
            // Frame end restarts tracking
            if (I_RX_EOP) begin
                d.len = 16'h0000;
                d.cut = 1'b0;
            end
        end

        // Fault levels
        d.ilf = I_TX_TEST_PATTERN | I_HI_BER |
                ~(&d.demux);
        d.rlf = rlf_lvl;

        // Events for the status register
        ev[EV_BAD]   = |d.bad;
        ev[EV_STOMP] = |d.stomp;
        ev[EV_TRUNC] = d.trunc;
        ev[EV_BIP]   = |d.bip;
        ev[EV_ILF]   = d.ilf & ~q.ilf;
        ev[EV_RLF]   = d.rlf & ~q.rlf;

        // Bus handshake: one stall cycle per request
        rd_acc    = I_AVM_READ  & ~q.waitreq;
        wr_acc    = I_AVM_WRITE & ~q.waitreq;
        d.waitreq = ~((I_AVM_READ | I_AVM_WRITE) & q.waitreq);

        // Register writes at the accepting edge
        if (wr_acc) begin
            unique case (I_AVM_ADDRESS)
                OFS_LIMIT: begin
                    wr_lim  = merge({17'h00000, q.limit}, I_AVM_WRITEDATA,
                                    I_AVM_BYTEENABLE);
                    d.limit = wr_lim[LEN_W-1:0];
                end
                OFS_IMSK: d.imsk = EV_W'(merge({26'h0000000, q.imsk},
                                    I_AVM_WRITEDATA, I_AVM_BYTEENABLE));
                OFS_IST:  d.ist = q.ist & ~EV_W'(I_AVM_WRITEDATA &
                                    be_mask(I_AVM_BYTEENABLE));
                default: d.limit = q.limit;
            endcase
        end
        // Set wins over a clear in the same cycle
        d.ist = d.ist | ev;
        d.irq = |(d.ist & d.imsk);

        // Read data prepared during the stall cycle
        d.rdata = 32'h00000000;
        if (I_AVM_READ & q.waitreq) begin
            unique case (I_AVM_ADDRESS)
                OFS_LIMIT: d.rdata = {17'h00000, q.limit};
                OFS_SYNC:  d.rdata = {12'h000, q.sync};
                OFS_DEMUX: d.rdata = {12'h000, q.demux};
                OFS_IST:   d.rdata = {26'h0000000, q.ist};
                OFS_IMSK:  d.rdata = {26'h0000000, q.imsk};
                OFS_FAULT: d.rdata = {30'h00000000, q.rlf, q.ilf};
                default:   d.rdata = 32'h00000000;
            endcase
        end else if (rd_acc) begin
            d.rdata = q.rdata;
        end
    end

    // State register
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            q         <= '0;
            q.limit   <= LIMIT_RST;
            q.waitreq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign O_AVM_READDATA            = q.rdata;
    assign O_AVM_WAITREQUEST         = q.waitreq;
    assign O_IRQ                     = q.irq;
    assign O_RX_LANE_MAP_INDEX       = q.map;
    assign O_RX_LANE_SYNC_FLAGS      = q.sync;
    assign O_RX_LANE_DEMUX_FLAGS     = q.demux;
    assign O_RX_BAD_CRC_COUNT        = q.bad;
    assign O_RX_POISONED_CRC_COUNT   = q.stomp;
    assign O_RX_TRUNCATED            = q.trunc;
    assign O_RX_INTERNAL_LOCAL_FAULT = q.ilf;
    assign O_RX_RECEIVED_LOCAL_FAULT = q.rlf;
    assign O_RX_LANE_PARITY_ERROR    = q.bip;

    // Checks
    property p_lane_map;
        @(posedge I_MCLK) disable iff (I_RESET)
        (I_PHYS_LANE[3].lock && I_PHYS_LANE[3].id == 5'h05)
            |=> O_RX_LANE_SYNC_FLAGS[5];
    endproperty
    a_lane_map: assert property (p_lane_map) else $error("lane 5 not synced");

    property p_unsynced_zero;
        @(posedge I_MCLK) disable iff (I_RESET)
        !O_RX_LANE_SYNC_FLAGS[0] |-> O_RX_LANE_MAP_INDEX[0] == 5'h00;
    endproperty
    a_unsynced_zero: assert property (p_unsynced_zero) else $error("index without sync");

    property p_demux_synced;
        @(posedge I_MCLK) disable iff (I_RESET)
        (O_RX_LANE_DEMUX_FLAGS & ~O_RX_LANE_SYNC_FLAGS) == 20'h00000;
    endproperty
    a_demux_synced: assert property (p_demux_synced) else $error("demux without sync");

    property p_stomp;
        @(posedge I_MCLK) disable iff (I_RESET)
        (I_FCS_SEG[0].valid && I_FCS_SEG[0].rx == ~I_FCS_SEG[0].calc)
            |=> O_RX_POISONED_CRC_COUNT != 4'h0;
    endproperty
    a_stomp: assert property (p_stomp) else $error("poisoned frame missed");

    property p_bad;
        @(posedge I_MCLK) disable iff (I_RESET)
        (I_FCS_SEG[0].valid && I_FCS_SEG[0].rx != I_FCS_SEG[0].calc &&
         I_FCS_SEG[0].rx != ~I_FCS_SEG[0].calc)
            |=> O_RX_BAD_CRC_COUNT != 4'h0;
    endproperty
    a_bad: assert property (p_bad) else $error("bad frame missed");

    property p_trunc_cause;
        @(posedge I_MCLK) disable iff (I_RESET)
        O_RX_TRUNCATED |-> $past(I_RX_VALID);
    endproperty
    a_trunc_cause: assert property (p_trunc_cause) else $error("truncation without data");

    property p_ilf;
        @(posedge I_MCLK) disable iff (I_RESET)
        (I_HI_BER || I_TX_TEST_PATTERN) |=> O_RX_INTERNAL_LOCAL_FAULT;
    endproperty
    a_ilf: assert property (p_ilf) else $error("internal fault not raised");

    property p_bip;
        @(posedge I_MCLK) disable iff (I_RESET)
        (I_BIP_CHK[0].valid && I_BIP_CHK[0].rx != I_BIP_CHK[0].calc)
            |=> O_RX_LANE_PARITY_ERROR[0];
    endproperty
    a_bip: assert property (p_bip) else $error("parity error missed");

    property p_bip_pulse;
        @(posedge I_MCLK) disable iff (I_RESET)
        !I_BIP_CHK[0].valid |=> !O_RX_LANE_PARITY_ERROR[0];
    endproperty
    a_bip_pulse: assert property (p_bip_pulse) else $error("parity pulse stuck");

    // No lane counts as demultiplexed before alignment
    property p_demux_deskew;
        @(posedge I_MCLK) disable iff (I_RESET)
        !I_DESKEW_DONE |=> O_RX_LANE_DEMUX_FLAGS == 20'h00000;
    endproperty
    a_demux_deskew: assert property (p_demux_deskew) else $error("demux before alignment");

    // Missing alignment raises the internal fault
    property p_ilf_align;
        @(posedge I_MCLK) disable iff (I_RESET)
        !I_DESKEW_DONE |=> O_RX_INTERNAL_LOCAL_FAULT;
    endproperty
    a_ilf_align: assert property (p_ilf_align) else $error("internal fault missing on bad alignment");
endmodule
`default_nettype wire

/* hw/rx_stat_pkg.sv */
// Shared constants and carrier types of the receive status block.
// Assumes a single receive clock for all users of these definitions.
package rx_stat_pkg;
    // Lane and segment geometry
    localparam int NUM_LANES = 20;   // PCS lanes
    localparam int LANE_W    = 5;    // Physical lane index width
    localparam int NUM_SEG   = 4;    // Frame-end segments per cycle
    localparam int CNT_W     = 4;    // Width of the CRC count outputs
    localparam int LEN_W     = 15;   // Length limit width
    localparam int BYTES_W   = 8;    // Width of the per-beat byte count

    // Register byte offsets
    localparam logic [7:0] OFS_LIMIT = 8'h00;  // Length limit, read/write
    localparam logic [7:0] OFS_SYNC  = 8'h04;  // Lane sync flags, read only
    localparam logic [7:0] OFS_DEMUX = 8'h08;  // Lane demux flags, read only
    localparam logic [7:0] OFS_IST   = 8'h0C;  // Event status, write one to clear
    localparam logic [7:0] OFS_IMSK  = 8'h10;  // Event mask, read/write
    localparam logic [7:0] OFS_FAULT = 8'h14;  // Fault levels, read only

    // Reset values
    localparam logic [LEN_W-1:0] LIMIT_RST = 15'h2580;  // 9600 bytes

    // Event bit positions in status and mask
    localparam int EV_BAD   = 0;
    localparam int EV_STOMP = 1;
    localparam int EV_TRUNC = 2;
    localparam int EV_BIP   = 3;
    localparam int EV_ILF   = 4;
    localparam int EV_RLF   = 5;
    localparam int EV_W     = 6;

    // Received local fault detector timing
    localparam int LF_TRIP   = 4;    // Sequences needed to trip
    localparam int LF_WINDOW = 128;  // Columns without a sequence to clear

    // One frame end with its received and computed CRC
    typedef struct packed {
        logic        valid;
        logic [31:0] rx;
        logic [31:0] calc;
    } fcs_seg_t;

    // One lane parity check
    typedef struct packed {
        logic       valid;
        logic [7:0] rx;
        logic [7:0] calc;
    } bip_chk_t;

    // Marker lock of one physical lane and the PCS lane it found
    typedef struct packed {
        logic        lock;
        logic [LANE_W-1:0] id;
    } phys_lane_t;
endpackage

/* hw/rx_fcs_classify.sv */
// Counts frame ends with a bad or a poisoned CRC in one cycle.
// Assumes the caller registers the counts.
`timescale 1ns/1ps
`default_nettype none
module rx_fcs_classify import rx_stat_pkg::*; (
    input  wire logic [NUM_SEG-1:0] i_seg_valid,    // Frame end per segment
    input  wire logic [NUM_SEG-1:0][31:0] i_seg_rx,   // Received CRC
    input  wire logic [NUM_SEG-1:0][31:0] i_seg_calc, // Computed CRC
    output logic [CNT_W-1:0]        o_bad_cnt,      // Plain bad count
    output logic [CNT_W-1:0]        o_stomp_cnt     // Poisoned count
);
    // Classify each segment and sum
    always_comb begin
        o_bad_cnt   = '0;
        o_stomp_cnt = '0;
        for (int s = 0; s < NUM_SEG; s++) begin
            if (i_seg_valid[s]) begin
                // Complemented CRC marks a poisoned frame
                if (i_seg_rx[s] == ~i_seg_calc[s]) begin
                    o_stomp_cnt = o_stomp_cnt + 4'h1;
                end else if (i_seg_rx[s] != i_seg_calc[s]) begin
                    o_bad_cnt = o_bad_cnt + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* hw/rx_lf_monitor.sv */
// Received local fault detector over link columns.
// Assumes column and sequence strobes on the receive clock.
`timescale 1ns/1ps
`default_nettype none
module rx_lf_monitor import rx_stat_pkg::*; #(
    parameter int TRIP   = LF_TRIP,
    parameter int WINDOW = LF_WINDOW
) (
    input  wire logic i_clk,       // Receive clock
    input  wire logic i_reset,     // Async reset, high
    input  wire logic i_col_valid, // A column arrived
    input  wire logic i_lf_seq,    // Column is a local fault sequence
    output logic      o_fault      // Fault level
);
    typedef enum logic [1:0] {
        LF_IDLE  = 2'b00,
        LF_COUNT = 2'b01,
        LF_FAULT = 2'b11
    } lf_state_t;

    typedef struct packed {
        lf_state_t  st;   // Detector state
        logic [2:0] seq;  // Sequences seen
        logic [7:0] col;  // Columns since last sequence
    } lf_reg_t;

    lf_reg_t q;
    lf_reg_t d;

    // Next state
    always_comb begin
        d = q;
        unique case (q.st)
            LF_IDLE: begin
                if (i_lf_seq) begin
                    d.st  = LF_COUNT;
                    d.seq = 3'h1;
                    d.col = 8'h00;
                end
            end
            LF_COUNT, LF_FAULT: begin
                if (i_lf_seq) begin
                    d.col = 8'h00;
                    // Enough sequences trip the fault
                    if (q.st == LF_COUNT && q.seq == 3'(TRIP - 1)) begin
                        d.st = LF_FAULT;
                    end else if (q.st == LF_COUNT) begin
                        d.seq = q.seq + 3'h1;
                    end
                end else if (i_col_valid) begin
                    // Quiet window ends the condition
                    if (q.col == 8'(WINDOW - 1)) begin
                        d.st = LF_IDLE;
                    end else begin
                        d.col = q.col + 8'h01;
                    end
                end
            end
            default: d.st = LF_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_fault = (q.st == LF_FAULT);

    property p_rlf_cause;
        @(posedge i_clk) disable iff (i_reset)
        $rose(o_fault) |-> $past(i_lf_seq);
    endproperty
    a_rlf_cause: assert property (p_rlf_cause) else $error("fault rose without sequence");
endmodule
`default_nettype wire

/* sim/rx_stat_sink.sv */
// User-side consumer of the receive status outputs.
// Assumes the receive clock and reset of the status block.
`timescale 1ns/1ps
`default_nettype none
module rx_stat_sink import rx_stat_pkg::*; (
    input  wire logic                          i_clk,    // Receive clock
    input  wire logic                          i_reset,  // Async reset
    input  wire logic [NUM_LANES-1:0][LANE_W-1:0] i_map, // Lane map
    input  wire logic [NUM_LANES-1:0]          i_sync,   // Synced flags
    input  wire logic [CNT_W-1:0]              i_bad,    // Bad CRC count
    input  wire logic [CNT_W-1:0]              i_poison, // Poisoned count
    output logic [15:0]                        o_bad_sum,    // Bad frames
    output logic [15:0]                        o_poison_sum, // Poisoned frames
    output logic [NUM_LANES-1:0][LANE_W-1:0]   o_map     // Trusted map
);
    // Running totals of the per-cycle counts; a map entry is trusted only while synced
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_bad_sum <= 16'h0000;
            o_poison_sum <= 16'h0000;
            o_map <= '1;
        end else begin
            o_bad_sum <= o_bad_sum + 16'(i_bad);
            o_poison_sum <= o_poison_sum + 16'(i_poison);
            for (int i = 0; i < NUM_LANES; i++) begin
                o_map[i] <= i_sync[i] ? i_map[i] : 5'h1F;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/rx_path_status_indicators_test.sv */
// Self-checking bench of the receive status block.
// Assumes the package and the sink model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rx_path_status_indicators_test import rx_stat_pkg::*; ;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, deskew = 1'b0;
    logic rxv = 1'b0, sop = 1'b0, eop = 1'b0, tpat = 1'b0, hiber = 1'b0;
    logic colv = 1'b0, lfs = 1'b0, wreq, irq, trunc, ilf, rlf;
    logic [7:0] addr = 8'h00, nb = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    phys_lane_t [NUM_LANES-1:0] phys = '0;   // Marker locks
    bip_chk_t [NUM_LANES-1:0] bip = '0;      // Parity checks
    fcs_seg_t [NUM_SEG-1:0] fcs = '0;        // Frame ends
    logic [NUM_LANES-1:0][LANE_W-1:0] map, smap;
    logic [NUM_LANES-1:0] sync, demux, perr;
    logic [CNT_W-1:0] bad, poi;
    logic [15:0] bsum, psum;
    int err_total = 0, checks = 0, cyc = 0;
    always #4 clk = ~clk;
    rx_status dut_u (.I_MCLK(clk), .I_RESET(rst), .I_AVM_ADDRESS(addr),
        .I_AVM_READ(rd), .I_AVM_WRITE(wr), .I_AVM_WRITEDATA(wdat),
        .I_AVM_BYTEENABLE(4'hF), .I_PHYS_LANE(phys), .I_DESKEW_DONE(deskew),
        .I_BIP_CHK(bip), .I_FCS_SEG(fcs), .I_RX_VALID(rxv), .I_RX_SOP(sop),
        .I_RX_EOP(eop), .I_RX_BYTES(nb), .I_TX_TEST_PATTERN(tpat),
        .I_HI_BER(hiber), .I_COL_VALID(colv), .I_LF_SEQ(lfs),
        .O_AVM_READDATA(rdat), .O_AVM_WAITREQUEST(wreq), .O_IRQ(irq),
        .O_RX_LANE_MAP_INDEX(map), .O_RX_LANE_SYNC_FLAGS(sync),
        .O_RX_LANE_DEMUX_FLAGS(demux), .O_RX_BAD_CRC_COUNT(bad),
        .O_RX_POISONED_CRC_COUNT(poi), .O_RX_TRUNCATED(trunc),
        .O_RX_INTERNAL_LOCAL_FAULT(ilf), .O_RX_RECEIVED_LOCAL_FAULT(rlf),
        .O_RX_LANE_PARITY_ERROR(perr));
    rx_stat_sink sink_u (.i_clk(clk), .i_reset(rst), .i_map(map),
        .i_sync(sync), .i_bad(bad), .i_poison(poi), .o_bad_sum(bsum),
        .o_poison_sum(psum), .o_map(smap));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // One edge; outputs read here still show the previous edge
    task automatic step;
        @(posedge clk);
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Limit register reset value, read back, unmapped place
    task automatic t_regs;
        bus(1'b0, OFS_LIMIT, 32'h0);
        chk(q, 32'h2580);
        bus(1'b1, OFS_LIMIT, 32'h10);
        bus(1'b0, OFS_LIMIT, 32'h0);
        chk(q, 32'h10);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        $display("test regs done");
    endtask
    // Lane map, sync, demux and internal fault causes
    task automatic t_lanes;
        chk(ilf, 1'b1);
        @(posedge clk);
        for (int p = 0; p < NUM_LANES; p++) phys[p] <= {1'b1, 5'((p + 2) % 20)};
        deskew <= 1'b1;
        step();
        step();
        for (int i = 0; i < NUM_LANES; i++) chk(map[i], 32'((i + 18) % 20));
        chk(sync, 20'hFFFFF);
        chk(demux, 20'hFFFFF);
        chk(ilf, 1'b0);
        hiber <= 1'b1;
        step();
        chk(smap[0], 5'h12);
        hiber <= 1'b0;
        tpat <= 1'b1;
        step();
        chk(ilf, 1'b1);
        tpat <= 1'b0;
        step();
        chk(ilf, 1'b1);
        step();
        chk(ilf, 1'b0);
        $display("test lanes done");
    endtask
    // Bad and poisoned CRC in back to back cycles, with interrupt
    task automatic t_crc;
        bus(1'b1, OFS_IST, 32'h3F);
        bus(1'b1, OFS_IMSK, 32'h1);
        @(posedge clk);
        fcs <= {{1'b1, 32'h1, 32'h2}, {1'b1, 32'h0F0F0F0F, 32'hF0F0F0F0},
                {1'b1, 32'h7, 32'h7}, {1'b1, 32'h5A5A5A5A, 32'hA5A5A5A5}};
        step();
        fcs <= {{3{65'h0}}, {1'b1, 32'h1, 32'h2}};
        step();
        fcs <= '0;
        chk(bad, 4'h1);
        chk(poi, 4'h2);
        step();
        chk(bad, 4'h1);
        chk(poi, 4'h0);
        step();
        chk(bad, 4'h0);
        chk(irq, 1'b1);
        bus(1'b0, OFS_IST, 32'h0);
        chk(q[1:0], 2'h3);
        bus(1'b1, OFS_IST, 32'h1);
        step();
        chk(irq, 1'b0);
        chk(bsum, 16'h2);
        chk(psum, 16'h2);
        $display("test crc done");
    endtask
    // Parity error only on the mismatching lane, one cycle
    task automatic t_bip;
        @(posedge clk);
        bip[19] <= {1'b1, 8'h11, 8'h11};
        bip[0] <= {1'b1, 8'h5A, 8'hA5};
        step();
        bip <= '0;
        step();
        chk(perr, 20'h00001);
        step();
        chk(perr, 20'h0);
        $display("test bip done");
    endtask
    // One beat of a frame and the truncation flag it causes
    task automatic beat(input logic s, e, input logic [7:0] n, input logic x);
        @(posedge clk);
        {rxv, sop, eop, nb} <= {1'b1, s, e, n};
        step();
        rxv <= 1'b0;
        step();
        chk(trunc, x);
    endtask
    // Frame passes the limit of 16 bytes at the third beat
    task automatic t_trunc;
        beat(1'b1, 1'b0, 8'h08, 1'b0);
        beat(1'b0, 1'b0, 8'h08, 1'b0);
        beat(1'b0, 1'b0, 8'h01, 1'b1);
        beat(1'b0, 1'b1, 8'h01, 1'b0);
        $display("test trunc done");
    endtask
    // Four fault sequences raise, a quiet window clears
    task automatic t_rlf;
        chk(rlf, 1'b0);
        @(posedge clk);
        colv <= 1'b1;
        lfs <= 1'b1;
        repeat (4) @(posedge clk);
        lfs <= 1'b0;
        step();
        step();
        chk(rlf, 1'b1);
        bus(1'b0, OFS_FAULT, 32'h0);
        chk(q, 32'h2);
        repeat (132) @(posedge clk);
        colv <= 1'b0;
        step();
        chk(rlf, 1'b0);
        $display("test rlf done");
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_lanes();
        t_crc();
        t_bip();
        t_trunc();
        t_rlf();
        test_done();
    end
endmodule
`default_nettype wire
